/* logic/csp_core_support.sv */
// Return stack, interrupt shadow context and indirect pointers of the CPU core.
// Assumes single-clock core logic driving all requests as one-cycle pulses.
`timescale 1ns/1ps
`include "csp_defs.svh"

module csp_core_support #(
	parameter int DEPTH = `CSP_STACK_DEPTH,
	parameter int WIDTH = `CSP_STACK_WIDTH
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Return stack
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [WIDTH-1:0] push_addr_i,
	output logic pop_valid_o,
	output logic [WIDTH-1:0] pop_addr_o,
	// Fault flags and reset
	input wire logic stack_fault_reset_enable_i,
	input wire logic ovf_clear_i,
	input wire logic unf_clear_i,
	output logic stack_overflow_flag_o,
	output logic stack_underflow_flag_o,
	output logic [7:0] status_o,
	output logic soft_reset_o,
	// Interrupt context
	input wire logic irq_entry_i,
	input wire logic irq_return_i,
	input wire csp_pkg::csp_ctx_type ctx_i,
	output logic restore_o,
	output csp_pkg::csp_ctx_type ctx_o,
	// Pointer write and readback
	input wire logic ptr_wr_i,
	input wire logic ptr_wsel_i,
	input wire logic [`CSP_PTR_WIDTH-1:0] ptr_wdata_i,
	output logic [`CSP_PTR_WIDTH-1:0] ptr0_o,
	output logic [`CSP_PTR_WIDTH-1:0] ptr1_o,
	// Operand address requests
	input wire logic req_i,
	input wire csp_pkg::csp_mode_type mode_i,
	input wire logic [5:0] opcode_i,
	input wire logic [8:0] operand_i,
	input wire logic [`CSP_BANK_BITS-1:0] bank_i,
	input wire logic [WIDTH-1:0] pc_i,
	input wire logic ptr_sel_i,
	output logic busy_o,
	output logic ea_valid_o,
	output logic [`CSP_FILE_AW-1:0] ea_file_o,
	output logic ea_prog_o,
	output logic [WIDTH-1:0] ea_prog_addr_o,
	output logic illegal_o
);
	import csp_pkg::*;

	csp_state_type st_q;
	csp_state_type st_d;
	csp_stack_if stk ();

	logic full;
	logic empty;
	assign full = st_q.count == `CSP_COUNT_WIDTH'(DEPTH);
	assign empty = st_q.count == '0;

	// ----------------------------------------
	// Stack storage
	// ----------------------------------------
	assign stk.we = push_i && !full;
	assign stk.waddr = st_q.count[`CSP_STACK_AW-1:0];
	assign stk.wdata = push_addr_i;
	assign stk.re = pop_i && !push_i && !empty;
	assign stk.raddr = `CSP_STACK_AW'(st_q.count - 1'b1);

	csp_stack_mem u_mem (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.stk(stk)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [`CSP_PTR_WIDTH-1:0] pv;
		logic [12:0] lin_off;
		logic [6:0] lin_bank;
		logic [6:0] lin_rem;
		pv = st_q.ptr[ptr_sel_i];
		lin_off = 13'(pv - `CSP_LIN_BASE);
		lin_bank = 7'(lin_off / `CSP_LIN_CHUNK);
		lin_rem = 7'(lin_off % `CSP_LIN_CHUNK);
		st_d = st_q;
		st_d.soft_rst = 1'b0;
		st_d.pop_valid = 1'b0;
		st_d.restore = 1'b0;
		st_d.ea_valid = 1'b0;
		st_d.illegal = 1'b0;
		// Clears first so a fault in the same cycle wins
		if (ovf_clear_i) begin
			st_d.ovf = 1'b0;
		end
		if (unf_clear_i) begin
			st_d.unf = 1'b0;
		end
		// Simultaneous push and pop: push is served, pop dropped
		if (push_i) begin
			if (full) begin
				st_d.ovf = 1'b1;
				st_d.soft_rst = stack_fault_reset_enable_i;
			end else begin
				st_d.count = st_q.count + 1'b1;
			end
		end else if (pop_i) begin
			if (empty) begin
				st_d.unf = 1'b1;
				st_d.soft_rst = stack_fault_reset_enable_i;
			end else begin
				st_d.count = st_q.count - 1'b1;
				st_d.pop_valid = 1'b1;
			end
		end
		if (irq_entry_i) begin
			st_d.shadow = ctx_i;
		end else if (irq_return_i) begin
			st_d.restore = 1'b1;
		end
		if (ptr_wr_i) begin
			st_d.ptr[ptr_wsel_i] = ptr_wdata_i;
		end
		// Requests during the extra fetch cycle are ignored
		if (st_q.phase == CSP_PH_FETCH) begin
			st_d.phase = CSP_PH_IDLE;
			st_d.ea_valid = 1'b1;
			st_d.ea_prog = 1'b1;
			st_d.ea_prog_addr = st_q.pend;
		end else if (req_i) begin
			if (opcode_i >= `CSP_INSN_COUNT) begin
				st_d.illegal = 1'b1;
			end else begin
				unique case (mode_i)
					CSP_MODE_DIRECT: begin
						st_d.ea_valid = 1'b1;
						st_d.ea_prog = 1'b0;
						st_d.ea_file = {bank_i, operand_i[6:0]};
					end
					CSP_MODE_INDIRECT: begin
						if (pv[`CSP_PROG_BIT]) begin
							st_d.phase = CSP_PH_FETCH;
							st_d.pend = pv[WIDTH-1:0];
						end else begin
							st_d.ea_valid = 1'b1;
							st_d.ea_prog = 1'b0;
							if (pv >= `CSP_LIN_BASE && pv <= `CSP_LIN_TOP) begin
								st_d.ea_file = `CSP_FILE_AW'(14'({lin_bank, 7'h00}) + `CSP_GPR_OFFSET
									+ 14'(lin_rem));
							end else if (pv < `CSP_LIN_BASE) begin
								st_d.ea_file = pv[`CSP_FILE_AW-1:0];
							end else begin
								// Unmapped pointer range lands on address zero
								st_d.ea_file = '0;
							end
						end
					end
					CSP_MODE_RELATIVE: begin
						st_d.ea_valid = 1'b1;
						st_d.ea_prog = 1'b1;
						st_d.ea_prog_addr = WIDTH'(pc_i + {{(WIDTH-9){operand_i[8]}}, operand_i});
					end
					default: begin
						st_d.illegal = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pop_valid_o = st_q.pop_valid;
	assign pop_addr_o = stk.rdata;
	assign stack_overflow_flag_o = st_q.ovf;
	assign stack_underflow_flag_o = st_q.unf;
	assign status_o = {st_q.ovf, st_q.unf, 6'h00};
	assign soft_reset_o = st_q.soft_rst;
	assign restore_o = st_q.restore;
	assign ctx_o = st_q.shadow;
	assign ptr0_o = st_q.ptr[0];
	assign ptr1_o = st_q.ptr[1];
	assign busy_o = st_q.phase == CSP_PH_FETCH;
	assign ea_valid_o = st_q.ea_valid;
	assign ea_file_o = st_q.ea_file;
	assign ea_prog_o = st_q.ea_prog;
	assign ea_prog_addr_o = st_q.ea_prog_addr;
	assign illegal_o = st_q.illegal;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	sequence s_prog_ind;
		req_i && !busy_o && opcode_i < `CSP_INSN_COUNT && mode_i == CSP_MODE_INDIRECT
			&& st_q.ptr[ptr_sel_i][`CSP_PROG_BIT];
	endsequence
	sequence s_fetch_done;
		busy_o && !ea_valid_o ##1 ea_valid_o && ea_prog_o && !busy_o;
	endsequence

	chk_depth_bound: assert property (st_q.count <= `CSP_COUNT_WIDTH'(DEPTH))
		else $error("stack count beyond depth");
	chk_push_full_ovf: assert property (push_i && full |=> stack_overflow_flag_o && $stable(st_q.count))
		else $error("overflow not flagged");
	chk_pop_empty_unf: assert property (!push_i && pop_i && empty |=> stack_underflow_flag_o && st_q.count == '0)
		else $error("underflow not flagged");
	chk_fault_reset: assert property ($rose(st_q.ovf) || $rose(st_q.unf)
		|-> soft_reset_o == $past(stack_fault_reset_enable_i))
		else $error("fault reset mismatch");
	chk_no_fault_rst: assert property (!stack_fault_reset_enable_i ##1 1 |-> !soft_reset_o)
		else $error("reset without enable");
	chk_shadow_restore: assert property (irq_entry_i ##1 (!irq_entry_i)[*2]
		|-> ctx_o == $past(ctx_i, 2))
		else $error("shadow context lost");
	chk_prog_extra: assert property (s_prog_ind |=> s_fetch_done)
		else $error("program fetch cycle wrong");
	chk_push_pop_data: assert property (push_i && !full ##1 !push_i && pop_i
		|=> pop_valid_o && pop_addr_o == $past(push_addr_i, 2))
		else $error("pop data mismatch");
	chk_status_zero: assert property (status_o[5:0] == 6'h00)
		else $error("unimplemented bits nonzero");
	chk_illegal_op: assert property (req_i && !busy_o && opcode_i >= `CSP_INSN_COUNT
		|=> illegal_o && !ea_valid_o)
		else $error("illegal opcode accepted");
	chk_direct_ea: assert property (req_i && !busy_o && opcode_i < `CSP_INSN_COUNT && mode_i == CSP_MODE_DIRECT
		|=> ea_valid_o && ea_file_o == $past({bank_i, operand_i[6:0]}))
		else $error("direct address wrong");
	chk_linear_map: assert property (req_i && !busy_o && opcode_i < `CSP_INSN_COUNT && mode_i == CSP_MODE_INDIRECT
		&& st_q.ptr[ptr_sel_i] == `CSP_LIN_BASE + 16'h0050 |=> ea_file_o == 12'h0A0)
		else $error("linear map wrong");
endmodule // csp_core_support

/* logic/csp_defs.svh */
// Constants of the core stack and pointer support block.
// Assumes inclusion by bare name from package and modules.
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// ----------------------------------------
// Return stack
// ----------------------------------------
`define CSP_STACK_DEPTH 16
`define CSP_STACK_WIDTH 15
`define CSP_STACK_AW 4
`define CSP_COUNT_WIDTH 5

// ----------------------------------------
// Pointers and memory map
// ----------------------------------------
`define CSP_PTR_WIDTH 16
`define CSP_PTR_COUNT 2
`define CSP_PROG_BIT 15
`define CSP_FILE_AW 12
`define CSP_LIN_BASE 16'h2000
`define CSP_LIN_TOP 16'h29AF
`define CSP_LIN_CHUNK 13'h0050
`define CSP_GPR_OFFSET 14'h0020
`define CSP_BANK_BITS 5

// ----------------------------------------
// Core context and instruction set
// ----------------------------------------
`define CSP_CTX_WIDTH 40
`define CSP_INSN_COUNT 6'h32
`define CSP_STAT_OVF_BIT 7
`define CSP_STAT_UNF_BIT 6

`endif

/* logic/csp_pkg.sv */
// Types shared by the core stack and pointer support block.
// Assumes csp_defs.svh is on the include path.
`include "csp_defs.svh"

package csp_pkg;

	typedef enum logic [1:0] {
		CSP_MODE_DIRECT = 2'b00,
		CSP_MODE_INDIRECT = 2'b01,
		CSP_MODE_RELATIVE = 2'b10
	} csp_mode_type;

	typedef enum logic {
		CSP_PH_IDLE = 1'b0,
		CSP_PH_FETCH = 1'b1
	} csp_phase_type;

	typedef logic [`CSP_CTX_WIDTH-1:0] csp_ctx_type;

	typedef struct packed {
		logic [`CSP_COUNT_WIDTH-1:0] count;
		logic ovf;
		logic unf;
		logic soft_rst;
		logic pop_valid;
		csp_ctx_type shadow;
		logic restore;
		logic [`CSP_PTR_COUNT-1:0][`CSP_PTR_WIDTH-1:0] ptr;
		csp_phase_type phase;
		logic [`CSP_STACK_WIDTH-1:0] pend;
		logic ea_valid;
		logic [`CSP_FILE_AW-1:0] ea_file;
		logic ea_prog;
		logic [`CSP_STACK_WIDTH-1:0] ea_prog_addr;
		logic illegal;
	} csp_state_type;

	typedef struct packed {
		logic [`CSP_STACK_DEPTH-1:0][`CSP_STACK_WIDTH-1:0] words;
		logic [`CSP_STACK_WIDTH-1:0] rdata;
	} csp_mem_state_type;

endpackage

/* logic/csp_stack_if.sv */
// Port bundle between the support block and its stack storage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "csp_defs.svh"

interface csp_stack_if;
	logic we;
	logic [`CSP_STACK_AW-1:0] waddr;
	logic [`CSP_STACK_WIDTH-1:0] wdata;
	logic re;
	logic [`CSP_STACK_AW-1:0] raddr;
	logic [`CSP_STACK_WIDTH-1:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

/* logic/csp_stack_mem.sv */
// Dedicated return stack storage with registered read data.
// Assumes the controller never reads and writes one word at once.
`timescale 1ns/1ps
`include "csp_defs.svh"

module csp_stack_mem (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Storage port
	csp_stack_if.mem stk
);
	import csp_pkg::*;

	csp_mem_state_type st_q;
	csp_mem_state_type st_d;

	always_comb begin
		st_d = st_q;
		if (stk.we) begin
			st_d.words[stk.waddr] = stk.wdata;
		end
		if (stk.re) begin
			st_d.rdata = st_q.words[stk.raddr];
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign stk.rdata = st_q.rdata;
endmodule // csp_stack_mem

/* verification/tb_top.sv */
// Self-checking bench for the core stack, shadow context and pointer block.
// Assumes the design files and csp_defs.svh are compiled first.
`timescale 1ns/1ps
`include "csp_defs.svh"

module tb_top;
	import csp_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clock_i, rstn_i, push_i, pop_i, pop_valid_o;
	logic [14:0] push_addr_i, pop_addr_o, pc_i, ea_prog_addr_o;
	logic stack_fault_reset_enable_i, ovf_clear_i, unf_clear_i;
	logic stack_overflow_flag_o, stack_underflow_flag_o, soft_reset_o;
	logic [7:0] status_o;
	logic irq_entry_i, irq_return_i, restore_o;
	csp_ctx_type ctx_i, ctx_o;
	logic ptr_wr_i, ptr_wsel_i, req_i, ptr_sel_i, busy_o, ea_valid_o, ea_prog_o, illegal_o;
	logic [15:0] ptr_wdata_i, ptr0_o, ptr1_o;
	csp_mode_type mode_i;
	logic [5:0] opcode_i;
	logic [8:0] operand_i;
	logic [4:0] bank_i;
	logic [11:0] ea_file_o;
	int fails, total_checks;

	csp_core_support dut (.*);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// Inputs move 1 ns after the edge so sampling never races
	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask

	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic ea(input logic [1:0] md, input logic [5:0] op, input logic [8:0] opd, input logic sel);
		// Let an edge pass so the request strobe is never re-raised in one step
		tick();
		mode_i = csp_mode_type'(md);
		opcode_i = op;
		operand_i = opd;
		ptr_sel_i = sel;
		req_i = 1'b1;
		tick();
		req_i = 1'b0;
	endtask

	task automatic wptr(input logic sel, input logic [15:0] v);
		ptr_wr_i = 1'b1;
		ptr_wsel_i = sel;
		ptr_wdata_i = v;
		tick();
		ptr_wr_i = 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_stack();
		stack_fault_reset_enable_i = 1'b0;
		push_addr_i = 15'h5a5a;
		push_i = 1'b1;
		tick();
		push_i = 1'b0;
		pop_i = 1'b1;
		tick();
		pop_i = 1'b0;
		chk("walk pop valid", 1, pop_valid_o);
		chk("walk pop addr", 15'h5a5a, pop_addr_o);
		push_i = 1'b1;
		for (int i = 0; i < 17; i++) begin
			push_addr_i = 15'(i * 16'h06a5 + 1);
			tick();
		end
		push_i = 1'b0;
		chk("ovf flag", 1, stack_overflow_flag_o);
		chk("status ovf", 8'h80, status_o);
		chk("no reset when off", 0, soft_reset_o);
		pop_i = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			tick();
			chk("pop valid", 1, pop_valid_o);
			chk("pop addr", 15'(i * 16'h06a5 + 1), pop_addr_o);
		end
		stack_fault_reset_enable_i = 1'b1;
		tick();
		pop_i = 1'b0;
		chk("no pop when empty", 0, pop_valid_o);
		chk("status both", 8'hc0, status_o);
		chk("unf flag", 1, stack_underflow_flag_o);
		chk("reset on fault", 1, soft_reset_o);
		tick();
		chk("reset pulse ends", 0, soft_reset_o);
		ovf_clear_i = 1'b1;
		unf_clear_i = 1'b1;
		pop_i = 1'b1;
		tick();
		pop_i = 1'b0;
		chk("set beats clear", 8'h40, status_o);
		tick();
		ovf_clear_i = 1'b0;
		unf_clear_i = 1'b0;
		tick();
		chk("status cleared", 8'h00, status_o);
		$display("test_stack finished");
	endtask

	task automatic test_shadow();
		ctx_i = 40'h12_3456_789a;
		irq_entry_i = 1'b1;
		tick();
		irq_entry_i = 1'b0;
		ctx_i = ~ctx_i;
		chk("shadow copy", 40'h12_3456_789a, ctx_o);
		irq_return_i = 1'b1;
		tick();
		irq_return_i = 1'b0;
		chk("restore pulse", 1, restore_o);
		chk("restored ctx", 40'h12_3456_789a, ctx_o);
		tick();
		chk("restore ends", 0, restore_o);
		$display("test_shadow finished");
	endtask

	task automatic test_pointers();
		logic [15:0] pv [4] = '{16'h0abc, 16'h2050, 16'h29af, 16'h29b0};
		logic [11:0] fa [4] = '{12'habc, 12'h0a0, 12'hf6f, 12'h000};
		wptr(1'b0, 16'h8123);
		chk("ptr0", 16'h8123, ptr0_o);
		ea(2'b01, 6'h01, 9'h000, 1'b0);
		chk("busy extra cycle", 1, busy_o);
		chk("no early result", 0, ea_valid_o);
		tick();
		chk("prog valid", 1, ea_valid_o);
		chk("prog flag", 1, ea_prog_o);
		chk("prog addr", 15'h0123, ea_prog_addr_o);
		chk("busy ends", 0, busy_o);
		for (int i = 0; i < 4; i++) begin
			wptr(1'b1, pv[i]);
			chk("ptr1", pv[i], ptr1_o);
			ea(2'b01, 6'h02, 9'h000, 1'b1);
			chk("file valid", 1, ea_valid_o);
			chk("file addr", fa[i], ea_file_o);
		end
		$display("test_pointers finished");
	endtask

	task automatic test_modes();
		bank_i = 5'h1f;
		pc_i = 15'h0010;
		ea(2'b00, 6'd49, 9'h1ff, 1'b0);
		chk("direct valid", 1, ea_valid_o);
		chk("direct addr", 12'hfff, ea_file_o);
		ea(2'b10, 6'd0, 9'h1f0, 1'b0);
		chk("relative addr", 15'h0000, ea_prog_addr_o);
		chk("relative prog", 1, ea_prog_o);
		ea(2'b00, 6'd50, 9'h001, 1'b0);
		chk("opcode 50 illegal", 1, illegal_o);
		chk("no address", 0, ea_valid_o);
		ea(2'b11, 6'd3, 9'h001, 1'b0);
		chk("mode 3 illegal", 1, illegal_o);
		$display("test_modes finished");
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		// About 73 cycles of traffic; 2000 is a generous margin
		#20000;
		fails++;
		conclude();
	end

	initial begin
		{push_i, pop_i, ovf_clear_i, unf_clear_i, irq_entry_i, irq_return_i} = '0;
		{ptr_wr_i, ptr_wsel_i, req_i, ptr_sel_i, stack_fault_reset_enable_i} = '0;
		push_addr_i = '0;
		pc_i = '0;
		ctx_i = '0;
		ptr_wdata_i = '0;
		mode_i = CSP_MODE_DIRECT;
		opcode_i = '0;
		operand_i = '0;
		bank_i = '0;
		fails = 0;
		total_checks = 0;
		rstn_i = 1'b0;
		repeat (5) tick();
		rstn_i = 1'b1;
		tick();
		test_stack();
		test_shadow();
		test_pointers();
		test_modes();
		conclude();
	end
endmodule // tb_top
